// ### ctc_cfg_regs.sv
/*
 * ctc_cfg_regs: clock tree configuration registers behind an AXI4-Lite
 * slave, with root switch tracking and bus stalls during a switch.
 * Assumes one outstanding write and one outstanding read from the master.
 */
`timescale 1ns/1ps
`default_nettype none
// Function
// - access waits at most two states
// - bit 31 marks pll band
// - pin codes 0000 to 0101 decoded
// - pin codes 0110 to 1110 decoded
// - usb divider three bit split code
// - multiplier codes up to 0E add two
// - code 0F is sixteen, upper add one
// - bit 17 predivides crystal
// - bit 16 picks pll reference
// - adc divider table as printed
// - apb2 divider at bits 13:11
// - apb1 divider codes 0xx and 100
// - apb1 codes 101 to 111, bits 10:8
// - root select two bit codes
module ctc_cfg_regs
	import ctc_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output var ctc_ctrl_s          clk_ctrl
);
	logic [31:0]       cfg_q;
	logic [31:0]       misc_q;
	logic [1:0]        sts_q;
	logic [1:0]        sw_cnt_q;
	logic [1:0]        sw_cnt_d;
	logic [1:0]        sw_sel_q;
	logic              stall_d;
	logic              awready_q;
	logic              wready_q;
	logic              aw_have_q;
	logic              w_have_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              arready_q;
	logic              rvalid_q;
	logic [31:0]       rdata_q;
	logic [1:0]        rresp_q;
	logic              aw_take;
	logic              w_take;
	logic              ar_take;
	logic              aw_have_d;
	logic              w_have_d;
	logic              bvalid_d;
	logic              rvalid_d;
	logic              do_write;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0]       wr_data;
	logic [3:0]        wr_strb;
	logic [31:0]       wr_bmask;
	logic              wr_cfg;
	logic              wr_misc;
	logic [1:0]        wr_sel;
	logic              sw_start;
	logic [31:0]       cfg_rd;
	logic [31:0]       dec_rd;
	ctc_ctrl_s         ctrl;

	// handshakes; protection bits carry no meaning here
	assign aw_take = s_axi_awvalid && awready_q;
	assign w_take  = s_axi_wvalid && wready_q;
	assign ar_take = s_axi_arvalid && arready_q;

	// address and data may arrive in either order
	assign wr_addr = aw_take ? s_axi_awaddr : awaddr_q;
	assign wr_data = w_take ? s_axi_wdata : wdata_q;
	assign wr_strb = w_take ? s_axi_wstrb : wstrb_q;
	assign do_write = (aw_have_q || aw_take) && (w_have_q || w_take) && !bvalid_q;

	genvar b;
	for (b = 0; b < 4; b++) begin : g_lane
		assign wr_bmask[b*8 +: 8] = {8{wr_strb[b]}};
	end

	assign wr_cfg  = do_write && (wr_addr == CFG_OFS);
	assign wr_misc = do_write && (wr_addr == MISC_OFS);
	assign wr_sel  = wr_strb[0] ? wr_data[SEL_LO +: 2] : cfg_q[SEL_LO +: 2];

	// reserved root code or the current root starts no switch
	assign sw_start = wr_cfg && (wr_sel != ROOT_RSVD) && (wr_sel != sts_q);

	// next switch count; a fresh switch restarts the wait
	always_comb begin
		if (sw_start)
			sw_cnt_d = SWITCH_WAIT;
		else if (sw_cnt_q != 2'h0)
			sw_cnt_d = sw_cnt_q - 2'h1;
		else
			sw_cnt_d = 2'h0;
		stall_d = (sw_cnt_d != 2'h0);
	end

	// write and read channel next state
	always_comb begin
		aw_have_d = (aw_have_q || aw_take) && !do_write;
		w_have_d  = (w_have_q || w_take) && !do_write;
		bvalid_d  = do_write || (bvalid_q && !s_axi_bready);
		rvalid_d  = ar_take || (rvalid_q && !s_axi_rready);
	end

	// write handshake flops; readies drop while the root settles
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			awready_q <= !stall_d && !aw_have_d && !bvalid_d;
			wready_q  <= !stall_d && !w_have_d && !bvalid_d;
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			bvalid_q  <= bvalid_d;
			if (do_write)
				bresp_q <= (wr_cfg || wr_misc) ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// captured write payload
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_q <= '0;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end else begin
			if (aw_take)
				awaddr_q <= s_axi_awaddr;
			if (w_take) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
		end
	end

	// configuration storage, byte lanes honoured
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_q  <= CFG_RESET;
			misc_q <= MISC_RESET;
		end else begin
			if (wr_cfg)
				cfg_q <= (cfg_q & ~(wr_bmask & CFG_WMASK)) | (wr_data & wr_bmask & CFG_WMASK);
			if (wr_misc)
				misc_q <= (misc_q & ~(wr_bmask & MISC_WMASK)) | (wr_data & wr_bmask & MISC_WMASK);
		end
	end

	// root switch: status follows select once the wait is over
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_cnt_q <= 2'h0;
			sw_sel_q <= ROOT_FAST_RC;
			sts_q    <= ROOT_FAST_RC;
		end else begin
			sw_cnt_q <= sw_cnt_d;
			if (sw_start)
				sw_sel_q <= wr_sel;
			if (sw_cnt_q == 2'h1 && !sw_start)
				sts_q <= sw_sel_q;
		end
	end

	// readback images; status field is read only
	always_comb begin
		cfg_rd = cfg_q & CFG_WMASK;
		cfg_rd[STS_LO +: 2] = sts_q;
		dec_rd = 32'h0000_0000;
		dec_rd[DEC_FACT_LO +: 7] = ctrl.pll_factor;
		dec_rd[DEC_USB_LO +: 4]  = ctrl.usb_div_half;
		dec_rd[DEC_ADC_LO +: 5]  = ctrl.adc_div;
		dec_rd[DEC_APB2_LO +: 3] = ctrl.apb2_shift;
		dec_rd[DEC_APB1_LO +: 3] = ctrl.apb1_shift;
		dec_rd[DEC_PIN_BIT]      = ctrl.pin_en;
		dec_rd[DEC_BUSY_BIT]     = (sw_cnt_q != 2'h0);
	end

	// read channel; unmapped reads answer slverr with zero data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= RESP_OKAY;
		end else begin
			arready_q <= !stall_d && !rvalid_d;
			rvalid_q  <= rvalid_d;
			if (ar_take) begin
				rresp_q <= RESP_OKAY;
				case (s_axi_araddr)
					CFG_OFS:  rdata_q <= cfg_rd;
					MISC_OFS: rdata_q <= misc_q & MISC_WMASK;
					DEC_OFS:  rdata_q <= dec_rd;
					default: begin
						rdata_q <= 32'h0000_0000;
						rresp_q <= RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// decoded clock tree settings, registered inside
	ctc_decode u_decode (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.cfg      (cfg_q),
		.misc     (misc_q),
		.root_sts (sts_q),
		.ctrl     (ctrl)
	);

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign clk_ctrl      = ctrl;

	property p_stall_len;
		@(posedge aclk) disable iff (!aresetn)
		(sw_cnt_q != 2'h0) |-> ##[1:2] (sw_cnt_q == 2'h0) || sw_start;
	endproperty
	a_stall_len: assert property (p_stall_len) else $error("switch stall too long");

	property p_ready_low;
		@(posedge aclk) disable iff (!aresetn)
		(sw_cnt_q != 2'h0) |-> !awready_q && !wready_q && !arready_q;
	endproperty
	a_ready_low: assert property (p_ready_low) else $error("ready high during switch");

	property p_band;
		@(posedge aclk) disable iff (!aresetn)
		(wr_cfg && wr_strb[3]) |=> ##1 (clk_ctrl.pll_band_high == $past(wr_data[BAND_BIT], 2));
	endproperty
	a_band: assert property (p_band) else $error("pll band not taken");

	property p_pin_msb;
		@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> (clk_ctrl.pin_src == {$past(misc_q[MISC_PIN_MSB]), $past(cfg_q[PIN_LO +: 3])});
	endproperty
	a_pin_msb: assert property (p_pin_msb) else $error("pin source msb misplaced");

	property p_switch;
		@(posedge aclk) disable iff (!aresetn)
		sw_start ##1 !sw_start [*2] |=> (sts_q == $past(sw_sel_q));
	endproperty
	a_switch: assert property (p_switch) else $error("root status not updated");

	property p_rsvd_root;
		@(posedge aclk) disable iff (!aresetn)
		(wr_cfg && wr_sel == ROOT_RSVD && sw_cnt_q == 2'h0) |=> $stable(sts_q);
	endproperty
	a_rsvd_root: assert property (p_rsvd_root) else $error("reserved root switched");

	property p_reset;
		@(posedge aclk) disable iff (!aresetn)
		$rose(aresetn) |-> (cfg_q == CFG_RESET) && (misc_q == MISC_RESET) && !bvalid_q;
	endproperty
	a_reset: assert property (p_reset) else $error("fields not reset to zero");

	property p_ref;
		@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> (clk_ctrl.pll_ref_xtal == $past(cfg_q[REF_BIT])) &&
			(clk_ctrl.pll_prediv == $past(cfg_q[PREDIV_BIT]));
	endproperty
	a_ref: assert property (p_ref) else $error("pll reference bits wrong");

	// writes to the current root must not stall the bus
	property p_same_root;
		@(posedge aclk) disable iff (!aresetn)
		(wr_cfg && wr_sel == sts_q && sw_cnt_q == 2'h0) |=> (sw_cnt_q == 2'h0);
	endproperty
	a_same_root: assert property (p_same_root) else $error("switch to current root");

	property p_sts_steady;
		@(posedge aclk) disable iff (!aresetn)
		(sw_cnt_q == 2'h0) |=> $stable(sts_q);
	endproperty
	a_sts_steady: assert property (p_sts_steady) else $error("root status moved idle");

	property p_write_ans;
		@(posedge aclk) disable iff (!aresetn)
		do_write |=> s_axi_bvalid;
	endproperty
	a_write_ans: assert property (p_write_ans) else $error("write not answered");

	property p_read_ans;
		@(posedge aclk) disable iff (!aresetn)
		ar_take |=> s_axi_rvalid;
	endproperty
	a_read_ans: assert property (p_read_ans) else $error("read not answered");

	property p_cfg_store;
		@(posedge aclk) disable iff (!aresetn)
		(wr_cfg && wr_bmask == 32'hFFFF_FFFF) |=> (cfg_q == ($past(wr_data) & CFG_WMASK));
	endproperty
	a_cfg_store: assert property (p_cfg_store) else $error("config word not stored");

	c_switch: cover property (@(posedge aclk) disable iff (!aresetn) sw_start);
	c_stalled: cover property (@(posedge aclk) disable iff (!aresetn)
		(sw_cnt_q != 2'h0) && s_axi_arvalid);
	c_write: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
	c_read: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
	c_rsvd: cover property (@(posedge aclk) disable iff (!aresetn) wr_cfg && wr_sel == ROOT_RSVD);
endmodule
`default_nettype wire

// ### ctc_decode.sv
/*
 * ctc_decode: turns raw configuration fields into registered divisor
 * and selector values for the clock tree.
 * Assumes raw fields come straight from the register flops.
 */
`timescale 1ns/1ps
`default_nettype none
module ctc_decode
	import ctc_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] cfg,
	input  wire logic [31:0] misc,
	input  wire logic [1:0]  root_sts,
	output var ctc_ctrl_s    ctrl
);
	logic [5:0]       mult_code;
	logic [2:0]       usb_code;
	logic [2:0]       adc_code;
	logic [3:0]       pin_code;
	logic [1:0][2:0]  bus_shift;
	ctc_ctrl_s        ctrl_d;
	ctc_ctrl_s        ctrl_q;

	// split fields are glued msb first
	assign mult_code = {cfg[MULT_HI_LO +: 2], cfg[MULT_LO_LO +: 4]};
	assign usb_code  = {cfg[USB_MSB_BIT], cfg[USB_LO +: 2]};
	assign adc_code  = {cfg[ADC_MSB_BIT], cfg[ADC_LO +: 2]};
	assign pin_code  = {misc[MISC_PIN_MSB], cfg[PIN_LO +: 3]};

	// both bus dividers share one code table
	genvar g;
	for (g = 0; g < 2; g++) begin : g_bus
		localparam int unsigned LO = (g == 0) ? APB1_LO : APB2_LO;
		assign bus_shift[g] = cfg[LO + 2] ? {1'b0, cfg[LO +: 2]} + 3'h1 : 3'h0;
	end

	// field decode
	always_comb begin
		ctrl_d = '0;
		ctrl_d.sys_root      = ctc_root_e'(root_sts);
		ctrl_d.pll_ref_xtal  = cfg[REF_BIT];
		ctrl_d.pll_prediv    = cfg[PREDIV_BIT];
		ctrl_d.pll_band_high = cfg[BAND_BIT];
		// code 0F repeats 16, so upper codes are only one above
		if (mult_code < 6'h0F)
			ctrl_d.pll_factor = {1'b0, mult_code} + 7'h02;
		else if (mult_code == 6'h0F)
			ctrl_d.pll_factor = 7'h10;
		else
			ctrl_d.pll_factor = {1'b0, mult_code} + 7'h01;
		case (usb_code)
			3'h0:    ctrl_d.usb_div_half = 4'h3;
			3'h1:    ctrl_d.usb_div_half = 4'h2;
			3'h2:    ctrl_d.usb_div_half = 4'h5;
			3'h3:    ctrl_d.usb_div_half = 4'h4;
			3'h4:    ctrl_d.usb_div_half = 4'h7;
			3'h5:    ctrl_d.usb_div_half = 4'h6;
			default: ctrl_d.usb_div_half = 4'h8;
		endcase
		// table kept as printed, including the repeated entries
		case (adc_code)
			3'h0:    ctrl_d.adc_div = 5'h02;
			3'h1:    ctrl_d.adc_div = 5'h04;
			3'h2:    ctrl_d.adc_div = 5'h06;
			3'h3:    ctrl_d.adc_div = 5'h08;
			3'h4:    ctrl_d.adc_div = 5'h02;
			3'h5:    ctrl_d.adc_div = 5'h0C;
			3'h6:    ctrl_d.adc_div = 5'h08;
			default: ctrl_d.adc_div = 5'h10;
		endcase
		ctrl_d.apb1_shift = bus_shift[0];
		ctrl_d.apb2_shift = bus_shift[1];
		ctrl_d.pin_src    = pin_code;
		// reserved pin codes leave the pin quiet
		case (pin_code)
			4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hD, 4'hE:
				ctrl_d.pin_en = 1'b1;
			default:
				ctrl_d.pin_en = 1'b0;
		endcase
	end

	// output register
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ctrl_q <= '0;
		else
			ctrl_q <= ctrl_d;
	end

	assign ctrl = ctrl_q;

	// sampled reset in each antecedent: the release edge still loads zeros
	property p_mult_low;
		@(posedge aclk) disable iff (!aresetn)
		(aresetn && mult_code < 6'h0F) |=>
			(ctrl.pll_factor == {1'b0, $past(mult_code)} + 7'h02);
	endproperty
	a_mult_low: assert property (p_mult_low) else $error("low pll factor wrong");

	property p_mult_high;
		@(posedge aclk) disable iff (!aresetn)
		(aresetn && mult_code >= 6'h0F) |=> (ctrl.pll_factor == (($past(mult_code) == 6'h0F) ?
			7'h10 : {1'b0, $past(mult_code)} + 7'h01));
	endproperty
	a_mult_high: assert property (p_mult_high) else $error("high pll factor wrong");

	property p_usb;
		@(posedge aclk) disable iff (!aresetn)
		(aresetn && usb_code == 3'h0) |=> (ctrl.usb_div_half == 4'h3);
	endproperty
	a_usb: assert property (p_usb) else $error("usb divisor wrong");

	property p_adc;
		@(posedge aclk) disable iff (!aresetn)
		(aresetn && adc_code == 3'h5) |=> (ctrl.adc_div == 5'h0C);
	endproperty
	a_adc: assert property (p_adc) else $error("adc divisor wrong");

	property p_apb;
		@(posedge aclk) disable iff (!aresetn)
		(aresetn && cfg[APB2_LO + 2] == 1'b0) |=> (ctrl.apb2_shift == 3'h0);
	endproperty
	a_apb: assert property (p_apb) else $error("apb2 not undivided");

	property p_pin;
		@(posedge aclk) disable iff (!aresetn)
		(aresetn && pin_code == 4'h1) |=> !ctrl.pin_en;
	endproperty
	a_pin: assert property (p_pin) else $error("reserved pin code drives");
endmodule
`default_nettype wire

// ### ctc_pkg.sv
/*
 * ctc_pkg: register map, field positions, reset values, timing counts
 * and the decoded control carrier of the clock tree configuration block.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
`default_nettype none
package ctc_pkg;

	// register map, byte addresses
	localparam int unsigned ADDR_W       = 8;
	localparam logic [7:0]  CFG_OFS      = 8'h04;
	localparam logic [7:0]  DEC_OFS      = 8'h08;
	localparam logic [7:0]  MISC_OFS     = 8'h30;

	// reset values and writable masks
	localparam logic [31:0] CFG_RESET    = 32'h0000_0000;
	localparam logic [31:0] MISC_RESET   = 32'h0000_0000;
	localparam logic [31:0] CFG_WMASK    = 32'hFFFF_FF03;
	localparam logic [31:0] MISC_WMASK   = 32'h0001_0000;

	// clock_configuration field positions
	localparam int unsigned BAND_BIT     = 31;
	localparam int unsigned MULT_HI_LO   = 29;
	localparam int unsigned ADC_MSB_BIT  = 28;
	localparam int unsigned USB_MSB_BIT  = 27;
	localparam int unsigned PIN_LO       = 24;
	localparam int unsigned USB_LO       = 22;
	localparam int unsigned MULT_LO_LO   = 18;
	localparam int unsigned PREDIV_BIT   = 17;
	localparam int unsigned REF_BIT      = 16;
	localparam int unsigned ADC_LO       = 14;
	localparam int unsigned APB2_LO      = 11;
	localparam int unsigned APB1_LO      = 8;
	localparam int unsigned STS_LO       = 2;
	localparam int unsigned SEL_LO       = 0;

	// misc_clock_register field positions
	localparam int unsigned MISC_PIN_MSB = 16;

	// decoded readback register layout
	localparam int unsigned DEC_FACT_LO  = 0;
	localparam int unsigned DEC_USB_LO   = 8;
	localparam int unsigned DEC_ADC_LO   = 12;
	localparam int unsigned DEC_APB2_LO  = 20;
	localparam int unsigned DEC_APB1_LO  = 24;
	localparam int unsigned DEC_PIN_BIT  = 28;
	localparam int unsigned DEC_BUSY_BIT = 31;

	// root switch settle time in bus clock cycles
	localparam logic [1:0]  SWITCH_WAIT  = 2'h2;

	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	typedef enum logic [1:0] {
		ROOT_FAST_RC = 2'h0,
		ROOT_CRYSTAL = 2'h1,
		ROOT_PLL     = 2'h2,
		ROOT_RSVD    = 2'h3
	} ctc_root_e;

	// decoded settings handed to the clock tree
	typedef struct packed {
		ctc_root_e  sys_root;      // active system root
		logic       pll_ref_xtal;  // 1: crystal path feeds the pll
		logic       pll_prediv;    // 1: crystal predivided
		logic       pll_band_high; // 1: pll above 72 MHz
		logic [6:0] pll_factor;    // 2..64
		logic [3:0] usb_div_half;  // usb divisor in half steps
		logic [4:0] adc_div;       // adc divisor of pclk
		logic [2:0] apb2_shift;    // log2 of apb2 divisor
		logic [2:0] apb1_shift;    // log2 of apb1 divisor
		logic [3:0] pin_src;       // clock pin source code
		logic       pin_en;        // clock pin driven
	} ctc_ctrl_s;

endpackage
`default_nettype wire

// ### test_clock_tree_config_register.sv
/*
 * test_clock_tree_config_register: self-checking bench for ctc_cfg_regs.
 * Assumes the ctc_pkg register map, a 100 MHz clock and a synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module test_clock_tree_config_register
	import ctc_pkg::*;
;
	logic              aclk;
	logic              aresetn;
	logic [ADDR_W-1:0] awaddr;
	logic [ADDR_W-1:0] araddr;
	logic [31:0]       wdata;
	logic              awvalid;
	logic              wvalid;
	logic              bready;
	logic              arvalid;
	logic              rready;
	logic              awready;
	logic              wready;
	logic              bvalid;
	logic              arready;
	logic              rvalid;
	logic [1:0]        bresp;
	logic [1:0]        rresp;
	logic [31:0]       rdata;
	ctc_ctrl_s         clk_ctrl;
	int                n_mismatch;
	int                num_checks;

	ctc_cfg_regs dut_u (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .clk_ctrl(clk_ctrl)
	);

	// free-running bus clock, 10 ns period
	initial aclk = 1'b0;
	always #5 aclk = ~aclk;

	task automatic end_of_test;
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// write master: address and data offered together, each released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp,
			output int waits);
		bit aw_ok;
		bit w_ok;
		int n;
		aw_ok = 0;
		w_ok = 0;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok) && n < 50) begin
			@(posedge aclk);
			n++;
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1;
				wvalid <= 1'b0;
			end
		end
		waits = n - 1;
		do begin
			@(posedge aclk);
			n++;
		end while (bvalid !== 1'b1 && n < 100);
		resp = bresp;
		bready <= 1'b0;
		chk(32'(n < 100), 32'h1, "write answer");
	endtask

	// read master: rready held until rvalid is sampled high
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp,
			output int waits);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (arready !== 1'b1 && n < 50);
		arvalid <= 1'b0;
		waits = n - 1;
		do begin
			@(posedge aclk);
			n++;
		end while (rvalid !== 1'b1 && n < 100);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
		chk(32'(n < 100), 32'h1, "read answer");
	endtask

	// plain write then a pause for the decoded outputs, which trail by a cycle
	task automatic put(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		int w;
		axi_wr(a, d, r, w);
		chk(32'(r), 32'(RESP_OKAY), "write resp");
		chk(32'(w), 32'h0, "write waits");
		repeat (2) @(posedge aclk);
		#1;
	endtask

	task automatic get(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] d;
		logic [1:0] r;
		int w;
		axi_rd(a, d, r, w);
		chk(32'(w), 32'h0, "read waits");
		chk(d, exp, what);
	endtask

	task automatic t_reset;
		#1;
		chk(32'(clk_ctrl.pll_factor), 32'h2, "reset factor");
		chk(32'(clk_ctrl.pin_en), 32'h0, "reset pin");
		chk(32'(clk_ctrl.sys_root), 32'(ROOT_FAST_RC), "reset root");
		get(CFG_OFS, CFG_RESET, "reset cfg");
		get(MISC_OFS, MISC_RESET, "reset misc");
		get(DEC_OFS, 32'h0000_2302, "reset decode");
	endtask

	task automatic t_mult;
		logic [5:0] codes [6] = '{6'h00, 6'h01, 6'h0E, 6'h0F, 6'h10, 6'h3F};
		logic [6:0] f;
		logic [31:0] v;
		foreach (codes[i]) begin
			f = (codes[i] <= 6'h0E) ? 7'(codes[i]) + 7'h2 : (codes[i] == 6'h0F) ? 7'h10 :
				7'(codes[i]) + 7'h1;
			// band kept consistent with a 4 MHz reference: above 72 MHz past x18
			v = (32'(f > 7'h12) << 31) | (32'(codes[i][5:4]) << 29) | (32'(codes[i][3:0]) << 18);
			put(CFG_OFS, v);
			chk(32'(clk_ctrl.pll_factor), 32'(f), "factor");
			chk(32'(clk_ctrl.pll_band_high), 32'(f > 7'h12), "band");
			get(CFG_OFS, v, "mult readback");
		end
	endtask

	task automatic t_div;
		logic [3:0] usb_t [8] = '{4'h3, 4'h2, 4'h5, 4'h4, 4'h7, 4'h6, 4'h8, 4'h8};
		logic [4:0] adc_t [8] = '{5'h02, 5'h04, 5'h06, 5'h08, 5'h02, 5'h0C, 5'h08, 5'h10};
		logic [2:0] c;
		logic [2:0] sh_t [8] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			put(CFG_OFS, (32'(c[2]) << 28) | (32'(c[2]) << 27) | (32'(c[1:0]) << 22) |
				(32'(c[1:0]) << 14) | (32'(c) << 11) | (32'(c) << 8));
			chk(32'(clk_ctrl.usb_div_half), 32'(usb_t[i]), "usb div");
			chk(32'(clk_ctrl.adc_div), 32'(adc_t[i]), "adc div");
			// slow bus clock here, so every divider keeps the peripheral buses legal
			chk(32'(clk_ctrl.apb2_shift), 32'(sh_t[i]), "apb2 div");
			chk(32'(clk_ctrl.apb1_shift), 32'(sh_t[i]), "apb1 div");
		end
	endtask

	task automatic t_ref;
		logic [2:0] k;
		for (int i = 0; i < 8; i++) begin
			k = 3'(i);
			put(CFG_OFS, (32'(k[2]) << 31) | (32'(k[1]) << 17) | (32'(k[0]) << 16));
			chk(32'(clk_ctrl.pll_band_high), 32'(k[2]), "band bit");
			chk(32'(clk_ctrl.pll_prediv), 32'(k[1]), "prediv");
			chk(32'(clk_ctrl.pll_ref_xtal), 32'(k[0]), "pll ref");
		end
	endtask

	task automatic t_pin;
		logic [15:0] en_mask;
		logic [3:0] k;
		en_mask = 16'h70FC;
		for (int i = 0; i < 16; i++) begin
			k = 4'(i);
			put(MISC_OFS, 32'(k[3]) << 16);
			put(CFG_OFS, 32'(k[2:0]) << 24);
			chk(32'(clk_ctrl.pin_src), 32'(k), "pin src");
			chk(32'(clk_ctrl.pin_en), 32'(en_mask[i]), "pin en");
		end
		put(MISC_OFS, 32'h0);
	endtask

	task automatic t_unmapped;
		logic [31:0] d;
		logic [1:0] r;
		int w;
		put(CFG_OFS, 32'h1234_5600);
		axi_rd(8'h10, d, r, w);
		chk(32'(r), 32'(RESP_SLVERR), "unmapped rresp");
		chk(d, 32'h0, "unmapped rdata");
		axi_wr(8'h10, 32'hFFFF_FFFF, r, w);
		chk(32'(r), 32'(RESP_SLVERR), "unmapped bresp");
		get(CFG_OFS, 32'h1234_5600, "cfg untouched");
	endtask

	// root switch: a read offered one cycle after the write lands in the stall, except after the reserved code
	task automatic t_switch;
		logic [1:0] sel [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
		logic [1:0] sts [4] = '{2'h2, 2'h2, 2'h1, 2'h0};
		logic [31:0] d;
		logic [1:0] r;
		logic [1:0] rr;
		int w;
		int rw;
		foreach (sel[i]) begin
			fork
				axi_wr(CFG_OFS, 32'(sel[i]), r, w);
				begin
					@(posedge aclk);
					axi_rd(CFG_OFS, d, rr, rw);
				end
			join
			if (sel[i] == 2'h3) begin
				chk(32'(rw), 32'h0, "no stall on reserved");
			end else begin
				chk(32'(rw >= 1 && rw <= 2), 32'h1, "stall length");
			end
			repeat (4) @(posedge aclk);
			#1;
			chk(32'(clk_ctrl.sys_root), 32'(sts[i]), "root");
			get(CFG_OFS, (32'(sts[i]) << 2) | 32'(sel[i]), "root status");
		end
	endtask

	// bounded run: the sequence needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		end_of_test;
	end

	initial begin
		n_mismatch = 0;
		num_checks = 0;
		aresetn = 1'b0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset;
		t_mult;
		t_div;
		t_ref;
		t_pin;
		t_unmapped;
		t_switch;
		end_of_test;
	end
endmodule
`default_nettype wire
